// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import uef_pkg::*;
  logic mclk, rstn, reg_wr, reg_rd, token_reject, buf_we, irq, rx_end;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [6:0] bd_count;
  logic [7:0] buf_wdata;
  uef_det_t det;
  uef_rx_t rx;
  int fails = 0;
  int n_tests = 0;
  int n_we = 0;
  // det, host mode, expected flag word
  logic [23:0] rows [9] = '{24'h800080, 24'h400010, 24'h200008, 24'h100004,
    24'h080002, 24'h050002, 24'h020001, 24'h090000, 24'h040000};
  uef_flags i_uef_flags (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .det(det), .rx(rx), .rx_end(rx_end), .bd_count(bd_count),
    .token_reject(token_reject), .buf_we(buf_we), .buf_waddr(),
    .buf_wdata(buf_wdata), .irq(irq));
  uef_far_model i_uef_far_model (.mclk(mclk), .rx(rx), .rx_end(rx_end));
  always @(posedge mclk) if (buf_we) n_we <= n_we + 1;
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("rdata", e, reg_rdata);
  endtask
  task pulse(input logic [6:0] d);
    @(posedge mclk);
    det <= d;
    @(posedge mclk);
    det <= '0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    fails++;
    wrap_up;
  end
  initial
  begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, det} = '0;
    bd_count = 7'h02;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rd(4'h0, 16'h0);
    rd(4'h8, 16'h0);
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'h00bf);
    rd(4'hc, 16'h0);
    foreach (rows[i])
    begin
      wr(4'h8, {15'h0, rows[i][16]});
      rd(4'h8, {15'h0, rows[i][16]});
      pulse(rows[i][23:17]);
      #1 chk("token_reject", rows[i][19] & ~rows[i][16], token_reject);
      rd(4'h0, rows[i][15:0]);
      chk("irq", rows[i][15:0] != 0, irq);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h0);
    end
    // excess byte dropped, flag raised
    i_uef_far_model.send(3);
    repeat (3) @(posedge mclk);
    chk("buffer writes", 16'h2, n_we[15:0]);
    rd(4'h0, 16'h0020);
    wr(4'h0, 16'h0020);
    // zero count drops a one-byte packet; the next packet starts clean
    bd_count <= 7'h00;
    i_uef_far_model.send(1);
    bd_count <= 7'h02;
    i_uef_far_model.send(2);
    repeat (3) @(posedge mclk);
    chk("buffer writes", 16'h4, n_we[15:0]);
    rd(4'h0, 16'h0020);
    wr(4'h0, 16'h0020);
    pulse(7'h41);
    wr(4'h0, 16'h0);
    rd(4'h0, 16'h0081);
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0080);
    wr(4'h4, 16'h0);
    #1 chk("masked irq", 16'h0, irq);
    // set and clear of one bit meet in one cycle
    @(posedge mclk);
    det <= 7'h01; reg_addr <= 4'h0; reg_wdata <= 16'h0081; reg_wr <= 1'b1;
    @(posedge mclk);
    det <= '0; reg_wr <= 1'b0;
    rd(4'h0, 16'h0001);
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    rd(4'h0, 16'h0);
    wrap_up;
  end
endmodule

bind uef_flags uef_flags_chk i_uef_flags_chk (.mclk(mclk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .det(det), .rx(rx), .token_reject(token_reject), .buf_we(buf_we),
  .buf_waddr(buf_waddr), .buf_wdata(buf_wdata), .irq(irq));

// ### uef_defs.svh
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define UEF_ADDR_W 4
`define UEF_OFS_FLAGS 4'h0
`define UEF_OFS_MASK 4'h4
`define UEF_OFS_CTRL 4'h8

// ---------------------------------------------------------------
// field positions of the flag word
// ---------------------------------------------------------------
`define UEF_BIT_STUFF 7
`define UEF_BIT_OVERRUN 5
`define UEF_BIT_TURNAROUND 4
`define UEF_BIT_LENGTH 3
`define UEF_BIT_CRC16 2
`define UEF_BIT_TOKEN_EOF 1
`define UEF_BIT_PID 0
`define UEF_IMPL_MASK 16'h00bf
`define UEF_FLAGS_RESET 16'h0000
`define UEF_MASK_RESET 16'h0000
`define UEF_BIT_HOST_MODE 0

// ---------------------------------------------------------------
// receive buffer
// ---------------------------------------------------------------
`define UEF_BUF_DEPTH 64
`define UEF_BUF_LIMIT 7'h40
`define UEF_BUF_AW 6
`define UEF_CNT_W 7

`endif

// ### uef_far_model.sv
`timescale 1ns/100ps
module uef_far_model (
  input wire logic mclk,
  output uef_pkg::uef_rx_t rx,
  output logic rx_end
);
  import uef_pkg::*;
  initial
  begin
    rx = '0;
    rx_end = 1'b0;
  end
  // idle data inverted so a stale byte never passes for a fresh one
  task send(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      rx <= '{1'b1, 8'ha0 + i[7:0], i == 0};
      rx_end <= (i == n - 1);
    end
    @(posedge mclk);
    rx <= '{1'b0, ~rx.data, 1'b0};
    rx_end <= 1'b0;
  endtask
endmodule

// ### uef_flags.sv
`timescale 1ns/100ps
`include "uef_defs.svh"

module uef_flags (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [`UEF_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire uef_pkg::uef_det_t det,
  input wire uef_pkg::uef_rx_t rx,
  input wire logic rx_end,
  input wire logic [`UEF_CNT_W-1:0] bd_count,
  output logic token_reject,
  output logic buf_we,
  output logic [`UEF_BUF_AW-1:0] buf_waddr,
  output logic [7:0] buf_wdata,
  output logic irq
);
  import uef_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0] flags_ff, nxt_flags;
  logic [15:0] mask_ff, nxt_mask;
  logic host_mode_ff, nxt_host_mode;
  logic [15:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic reject_ff, nxt_reject;

  // ---------------------------------------------------------------
  // receive path state
  // ---------------------------------------------------------------
  uef_state_t state_ff, nxt_state;
  logic [`UEF_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [`UEF_CNT_W-1:0] limit_ff, nxt_limit;
  logic we_ff, nxt_we;
  logic [`UEF_BUF_AW-1:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic overrun_ev;

  // ---------------------------------------------------------------
  // address decode and byte room
  // ---------------------------------------------------------------
  function automatic logic addr_is(input logic [`UEF_ADDR_W-1:0] a,
                                   input logic [`UEF_ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  function automatic logic wr_hit(input logic wr,
                                  input logic [`UEF_ADDR_W-1:0] a,
                                  input logic [`UEF_ADDR_W-1:0] ofs);
    wr_hit = wr && addr_is(a, ofs);
  endfunction

  // room is bounded by the descriptor and by the buffer, whichever is less
  function automatic logic byte_fits(input logic [`UEF_CNT_W-1:0] cnt,
                                     input logic [`UEF_CNT_W-1:0] limit);
    byte_fits = (cnt < limit) && (cnt < `UEF_BUF_LIMIT);
  endfunction

  // ---------------------------------------------------------------
  // byte counting against the descriptor count
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_limit = limit_ff;
    nxt_we = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    overrun_ev = 1'b0;
    // every byte past the room is one overrun event
    unique case (state_ff)
      UEF_IDLE:
      begin
        if (rx.valid && rx.first)
        begin
          // count latched at packet start so a changing input cannot shift it
          nxt_limit = bd_count;
          // a one-byte packet may end on its first byte
          if (!rx_end)
          begin
            nxt_state = UEF_RECV;
          end
          if (byte_fits('0, bd_count))
          begin
            nxt_we = 1'b1;
            nxt_waddr = '0;
            nxt_wdata = rx.data;
            nxt_cnt = 7'h01;
          end
          else
          begin
            nxt_cnt = '0;
            overrun_ev = 1'b1;
          end
        end
      end
      UEF_RECV:
      begin
        if (rx.valid)
        begin
          if (byte_fits(cnt_ff, limit_ff))
          begin
            nxt_we = 1'b1;
            nxt_waddr = cnt_ff[`UEF_BUF_AW-1:0];
            nxt_wdata = rx.data;
            nxt_cnt = cnt_ff + 7'h01;
          end
          else
          begin
            overrun_ev = 1'b1; // excess byte dropped
          end
        end
        // rx_end may share the cycle of the last byte
        if (rx_end)
        begin
          nxt_state = UEF_IDLE;
        end
      end
      default:
      begin
        // unused codes fall back to idle
        nxt_state = UEF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= UEF_IDLE;
      cnt_ff <= '0;
      limit_ff <= '0;
      we_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      limit_ff <= nxt_limit;
      we_ff <= nxt_we;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
    end
  end

  // ---------------------------------------------------------------
  // error flags
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [15:0] set_v;
    logic [15:0] clr_v;
    set_v = 16'h0000;
    clr_v = 16'h0000;
    set_v[`UEF_BIT_STUFF] = det.stuff_err;
    set_v[`UEF_BIT_OVERRUN] = overrun_ev;
    set_v[`UEF_BIT_TURNAROUND] = det.turnaround_to;
    set_v[`UEF_BIT_LENGTH] = det.length_err;
    set_v[`UEF_BIT_CRC16] = det.crc16_err;
    // one bit, two meanings picked by mode
    set_v[`UEF_BIT_TOKEN_EOF] = host_mode_ff ? det.eof_err : det.crc5_err;
    set_v[`UEF_BIT_PID] = det.pid_err;
    if (wr_hit(reg_wr, reg_addr, `UEF_OFS_FLAGS))
    begin
      // whole word taken: every one bit clears its flag
      clr_v = reg_wdata & `UEF_IMPL_MASK;
    end
    // set wins over clear, flags otherwise hold
    nxt_flags = ((flags_ff & ~clr_v) | set_v) & `UEF_IMPL_MASK;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_ff <= `UEF_FLAGS_RESET;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end

  // ---------------------------------------------------------------
  // mask and mode control
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_mask = mask_ff;
    nxt_host_mode = host_mode_ff;
    if (wr_hit(reg_wr, reg_addr, `UEF_OFS_MASK))
    begin
      nxt_mask = reg_wdata & `UEF_IMPL_MASK;
    end
    // a mode change leaves flags already raised untouched
    if (wr_hit(reg_wr, reg_addr, `UEF_OFS_CTRL))
    begin
      nxt_host_mode = reg_wdata[`UEF_BIT_HOST_MODE];
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_ff <= `UEF_MASK_RESET;
      host_mode_ff <= 1'b0;
    end
    else
    begin
      mask_ff <= nxt_mask;
      host_mode_ff <= nxt_host_mode;
    end
  end

  // ---------------------------------------------------------------
  // read port: data stand only in the cycle after the strobe
  // ---------------------------------------------------------------
  always_comb
  begin
    // unmapped offsets fall through to zero
    nxt_rdata = 16'h0000;
    if (reg_rd)
    begin
      if (addr_is(reg_addr, `UEF_OFS_FLAGS))
      begin
        nxt_rdata = flags_ff;
      end
      else if (addr_is(reg_addr, `UEF_OFS_MASK))
      begin
        nxt_rdata = mask_ff;
      end
      else if (addr_is(reg_addr, `UEF_OFS_CTRL))
      begin
        nxt_rdata = {15'h0000, host_mode_ff};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // interrupt and token reject
  // ---------------------------------------------------------------
  always_comb
  begin
    // built from next values so irq moves on the same edge as the flag
    nxt_irq = |(nxt_flags & nxt_mask);
    // only token CRC errors in device mode cause a rejection
    nxt_reject = det.crc5_err && !host_mode_ff;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ff <= 1'b0;
      reject_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
      reject_ff <= nxt_reject;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign token_reject = reject_ff;
  assign buf_we = we_ff;
  assign buf_waddr = waddr_ff;
  assign buf_wdata = wdata_ff;
endmodule

// ### uef_flags_chk.sv
`timescale 1ns/100ps
module uef_flags_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire uef_pkg::uef_det_t det,
  input wire uef_pkg::uef_rx_t rx,
  input wire logic token_reject,
  input wire logic buf_we,
  input wire logic [5:0] buf_waddr,
  input wire logic [7:0] buf_wdata,
  input wire logic irq
);
  import uef_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rd_gap; !reg_rd |=> reg_rdata == 16'h0; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read data outside read slot");
  property p_rst; !$past(rstn) |-> !irq && !token_reject && !buf_we; endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  property p_keep; irq && !reg_wr |=> irq; endproperty
  a_keep: assert property (p_keep) else $error("irq dropped without write");
  property p_hw; !irq && !reg_wr && det == '0 && !rx.valid |=> !irq; endproperty
  a_hw: assert property (p_hw) else $error("irq rose without event");
  property p_hole; reg_rd |=> reg_rdata[15:8] == 8'h0 && !reg_rdata[6]; endproperty
  a_hole: assert property (p_hole) else $error("unimplemented bit reads one");
  property p_tok; token_reject |-> $past(det.crc5_err); endproperty
  a_tok: assert property (p_tok) else $error("token reject without crc5 error");
  property p_buf; buf_we |-> $past(rx.valid) && buf_wdata == $past(rx.data); endproperty
  a_buf: assert property (p_buf) else $error("buffer write not from byte");
  property p_unm; reg_rd && reg_addr == 4'hc |=> reg_rdata == 16'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_waddr0; buf_we && $past(rx.first) |-> buf_waddr == 6'h0; endproperty
  a_waddr0: assert property (p_waddr0) else $error("packet not stored from slot zero");
  property p_wnext;
    buf_we && !$past(rx.first) |-> buf_waddr == $past(buf_waddr) + 6'h1;
  endproperty
  a_wnext: assert property (p_wnext) else $error("stored bytes not in order");
endmodule

// ### uef_pkg.sv
package uef_pkg;
  typedef struct packed {
    logic stuff_err;
    logic turnaround_to;
    logic length_err;
    logic crc16_err;
    logic crc5_err;
    logic eof_err;
    logic pid_err;
  } uef_det_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic first;
  } uef_rx_t;

  typedef enum logic [1:0] {
    UEF_IDLE,
    UEF_RECV
  } uef_state_t;
endpackage
